/* rtl/shfla_defs.svh */
// Constants for the sync header stream encoder with FEC parity.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SHFLA_DEFS_SVH
`define SHFLA_DEFS_SVH

`define SHFLA_MODE_FEC 2'h2
`define SHFLA_BLK_BITS 64
`define SHFLA_BLKS_PER_MB 32
`define SHFLA_MB_BITS 2048
`define SHFLA_PAR_W 26
`define SHFLA_POLY 26'h022_0211
`define SHFLA_EOEMB_POS 22
`define SHFLA_PAR_HI_LAST 21
`define SHFLA_PAR_LO_FIRST 23
`define SHFLA_PILOT_FIRST 27
`define SHFLA_PILOT 5'h01
`define SHFLA_HDR_ONE 2'h1
`define SHFLA_HDR_ZERO 2'h2
`define SHFLA_LAST_BLK 5'h1F
`define SHFLA_PE_W 4

`endif

/* rtl/shfla_pkg.sv */
// Types for the sync header stream encoder.
// Assumes shfla_defs.svh is reachable on the include path.
`include "shfla_defs.svh"

package shfla_pkg;
	typedef struct packed {
		logic [1:0] hdr;
		logic [`SHFLA_BLK_BITS-1:0] data;
	} shfla_blk_type;

	typedef enum logic [1:0] {
		SHFLA_OFF = 2'h0,
		SHFLA_START = 2'h1,
		SHFLA_RUN = 2'h3
	} shfla_state_type;
endpackage

/* rtl/shfla_parity_gen.sv */
// Parity shift register for the (2074, 2048) shortened cyclic code.
// Assumes one 64-bit scrambled block per valid cycle, most significant bit first.
`timescale 1ns/1ps
`default_nettype none
`include "shfla_defs.svh"

module shfla_parity_gen #(
	parameter int DATA_W = `SHFLA_BLK_BITS
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic valid,
	input wire logic restart,
	input wire logic [DATA_W-1:0] data,
	output logic [`SHFLA_PAR_W-1:0] parity_next
);
	logic [`SHFLA_PAR_W-1:0] state_q;
	logic [`SHFLA_PAR_W-1:0] state_d;

	function automatic logic [`SHFLA_PAR_W-1:0] shfla_step(input logic [`SHFLA_PAR_W-1:0] s_in,
			input logic [DATA_W-1:0] d);
		logic [`SHFLA_PAR_W-1:0] s;
		logic fb;
		s = s_in;
		fb = 1'b0;
		for (int i = DATA_W - 1; i >= 0; i--) begin
			fb = d[i] ^ s[`SHFLA_PAR_W-1];
			s = {s[`SHFLA_PAR_W-2:0], 1'b0} ^ (fb ? `SHFLA_POLY : '0);
		end
		return s;
	endfunction

	always_comb begin
		parity_next = shfla_step(restart ? '0 : state_q, data);
		state_d = valid ? parity_next : state_q;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	property p_hold_idle;
		@(posedge clock) disable iff (rst)
		!valid |=> state_q == $past(state_q);
	endproperty
	a_hold_idle: assert property (p_hold_idle) else $error("Parity state moved without a block");

	property p_restart_from_zero;
		@(posedge clock) disable iff (rst)
		valid && restart && data == '0 |=> state_q == '0;
	endproperty
	a_restart_from_zero: assert property (p_restart_from_zero) else $error("Parity did not restart from zero");
endmodule // shfla_parity_gen

`default_nettype wire

/* rtl/shfla_tx_link.sv */
// Transmit sync header stream encoder: FEC parity, pilot, end flag, enable.
// Assumes scrambled blocks arrive one per valid cycle and sysref_pulse is one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "shfla_defs.svh"

module shfla_tx_link #(
	parameter int EMB_W = 8,
	parameter int PE_W = `SHFLA_PE_W
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic link_block_enable,
	input wire logic [1:0] sync_header_mode_select,
	input wire logic [PE_W-1:0] serializer_preemphasis_level,
	input wire logic [EMB_W-1:0] emb_multiblocks,
	input wire logic sysref_pulse,
	input wire logic blk_valid,
	input wire logic [`SHFLA_BLK_BITS-1:0] blk_data,
	output logic tx_valid,
	output shfla_pkg::shfla_blk_type tx_block,
	output logic [4:0] tx_block_index,
	output logic tx_emb_end,
	output logic lemc_edge,
	output logic fec_active,
	output logic [`SHFLA_PAR_W-1:0] parity_last,
	output logic serializer_power_down,
	output logic link_clock_enable,
	output logic [PE_W-1:0] preemph_drive
);
	shfla_pkg::shfla_state_type state_q;
	shfla_pkg::shfla_state_type state_d;
	logic [4:0] blk_cnt_q;
	logic [4:0] blk_cnt_d;
	logic [EMB_W-1:0] mb_cnt_q;
	logic [EMB_W-1:0] mb_cnt_d;
	logic [`SHFLA_PAR_W-1:0] hold_q;
	logic [`SHFLA_PAR_W-1:0] hold_d;
	logic [`SHFLA_PAR_W-1:0] par_next;
	logic tx_valid_d;
	shfla_pkg::shfla_blk_type tx_block_d;
	logic [4:0] tx_idx_d;
	logic tx_emb_end_d;
	logic lemc_edge_d;
	logic fec_d;
	logic pd_d;
	logic clk_en_d;
	logic [PE_W-1:0] pe_d;
	logic take;
	logic cur_idx_zero;
	logic [4:0] cur_idx;
	logic [EMB_W-1:0] cur_mb;
	logic last_mb;
	logic [31:0] stream;

	// Block counts restart from zero on the timing reference pulse
	always_comb begin
		state_d = state_q;
		case (state_q)
			shfla_pkg::SHFLA_OFF: state_d = shfla_pkg::SHFLA_START;
			shfla_pkg::SHFLA_START: if (sysref_pulse) state_d = shfla_pkg::SHFLA_RUN;
			shfla_pkg::SHFLA_RUN: state_d = shfla_pkg::SHFLA_RUN;
			default: state_d = shfla_pkg::SHFLA_OFF;
		endcase
		if (!link_block_enable) begin
			state_d = shfla_pkg::SHFLA_OFF;
		end
		take = link_block_enable && blk_valid && (state_q == shfla_pkg::SHFLA_RUN
			|| (state_q == shfla_pkg::SHFLA_START && sysref_pulse));
		cur_idx = sysref_pulse ? 5'h00 : blk_cnt_q;
		cur_mb = sysref_pulse ? '0 : mb_cnt_q;
		cur_idx_zero = cur_idx == 5'h00;
		last_mb = emb_multiblocks == '0 || cur_mb >= emb_multiblocks - EMB_W'(1);
		blk_cnt_d = blk_cnt_q;
		mb_cnt_d = mb_cnt_q;
		if (take) begin
			blk_cnt_d = cur_idx + 5'h01;
			mb_cnt_d = cur_mb;
			if (cur_idx == `SHFLA_LAST_BLK) begin
				mb_cnt_d = last_mb ? '0 : cur_mb + EMB_W'(1);
			end
		end else if (sysref_pulse) begin
			blk_cnt_d = 5'h00;
			mb_cnt_d = '0;
		end
		if (state_d == shfla_pkg::SHFLA_OFF) begin
			blk_cnt_d = 5'h00;
			mb_cnt_d = '0;
		end
	end

	shfla_parity_gen #(
		.DATA_W(`SHFLA_BLK_BITS)
	) u_parity (
		.clock(clock),
		.rst(rst || !link_block_enable),
		.valid(take),
		.restart(cur_idx_zero),
		.data(blk_data),
		.parity_next(par_next)
	);

	// Stream word for the multiblock now being sent
	always_comb begin
		fec_d = sync_header_mode_select == `SHFLA_MODE_FEC;
		stream = '0;
		for (int i = 0; i <= `SHFLA_PAR_HI_LAST; i++) begin
			stream[i] = fec_d & hold_q[`SHFLA_PAR_W-1-i];
		end
		stream[`SHFLA_EOEMB_POS] = last_mb;
		for (int i = 0; i < 4; i++) begin
			stream[`SHFLA_PAR_LO_FIRST+i] = fec_d & hold_q[3-i];
		end
		for (int i = 0; i < 5; i++) begin
			stream[`SHFLA_PILOT_FIRST+i] = 1'(`SHFLA_PILOT >> (4 - i));
		end
		hold_d = hold_q;
		if (take && cur_idx == `SHFLA_LAST_BLK) begin
			hold_d = par_next;
		end
		if (state_d == shfla_pkg::SHFLA_OFF) begin
			hold_d = '0;
		end
		tx_valid_d = take;
		tx_block_d.data = take ? blk_data : tx_block.data;
		tx_block_d.hdr = stream[cur_idx] ? `SHFLA_HDR_ONE : `SHFLA_HDR_ZERO;
		if (!take) begin
			tx_block_d.hdr = tx_block.hdr;
		end
		tx_idx_d = take ? cur_idx : tx_block_index;
		tx_emb_end_d = take ? last_mb : tx_emb_end;
		lemc_edge_d = take && cur_idx_zero && cur_mb == '0;
		pd_d = !link_block_enable;
		clk_en_d = link_block_enable;
		pe_d = serializer_preemphasis_level;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= shfla_pkg::SHFLA_OFF;
			blk_cnt_q <= 5'h00;
			mb_cnt_q <= '0;
			hold_q <= '0;
			tx_valid <= 1'b0;
			tx_block <= '0;
			tx_block_index <= 5'h00;
			tx_emb_end <= 1'b0;
			lemc_edge <= 1'b0;
			fec_active <= 1'b0;
			serializer_power_down <= 1'b1;
			link_clock_enable <= 1'b0;
			preemph_drive <= '0;
		end else begin
			state_q <= state_d;
			blk_cnt_q <= blk_cnt_d;
			mb_cnt_q <= mb_cnt_d;
			hold_q <= hold_d;
			tx_valid <= tx_valid_d;
			tx_block <= tx_block_d;
			tx_block_index <= tx_idx_d;
			tx_emb_end <= tx_emb_end_d;
			lemc_edge <= lemc_edge_d;
			fec_active <= fec_d;
			serializer_power_down <= pd_d;
			link_clock_enable <= clk_en_d;
			preemph_drive <= pe_d;
		end
	end

	always_comb parity_last = hold_q;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_pilot_zeros;
		tx_valid && tx_block_index >= 5'd27 && tx_block_index <= 5'd30 |-> tx_block.hdr == `SHFLA_HDR_ZERO;
	endproperty
	a_pilot_zeros: assert property (p_pilot_zeros) else $error("Pilot zero bit wrong");

	property p_pilot_one;
		tx_valid && tx_block_index == `SHFLA_LAST_BLK |-> tx_block.hdr == `SHFLA_HDR_ONE;
	endproperty
	a_pilot_one: assert property (p_pilot_one) else $error("Pilot final one wrong");

	property p_hdr_legal;
		tx_valid |-> tx_block.hdr == `SHFLA_HDR_ONE || tx_block.hdr == `SHFLA_HDR_ZERO;
	endproperty
	a_hdr_legal: assert property (p_hdr_legal) else $error("Illegal sync header");

	property p_eoemb;
		tx_valid && tx_block_index == 5'd22 |-> tx_block.hdr == (tx_emb_end ? `SHFLA_HDR_ONE : `SHFLA_HDR_ZERO);
	endproperty
	a_eoemb: assert property (p_eoemb) else $error("End flag wrong");

	property p_disabled;
		!link_block_enable |=> serializer_power_down && !link_clock_enable && !tx_valid;
	endproperty
	a_disabled: assert property (p_disabled) else $error("Disabled link still active");

	property p_sysref_phase;
		link_block_enable && $past(link_block_enable) && !$past(rst) && sysref_pulse && blk_valid
			|=> tx_valid && tx_block_index == 5'h00 && lemc_edge;
	endproperty
	a_sysref_phase: assert property (p_sysref_phase) else $error("Timing reference did not reset phase");

	property p_parity_map;
		tx_valid && fec_active && tx_block_index <= 5'd21 && $stable(parity_last)
			|-> tx_block.hdr[0] == parity_last[5'd25 - tx_block_index];
	endproperty
	a_parity_map: assert property (p_parity_map) else $error("Parity bit mapped wrong");

	property p_non_fec;
		tx_valid && !fec_active && tx_block_index != 5'd22 && tx_block_index < 5'd27
			|-> tx_block.hdr == `SHFLA_HDR_ZERO;
	endproperty
	a_non_fec: assert property (p_non_fec) else $error("Parity sent outside FEC mode");

	property p_parity_latch;
		link_block_enable && tx_valid && tx_block_index != `SHFLA_LAST_BLK
			##1 link_block_enable && !(tx_valid && tx_block_index == `SHFLA_LAST_BLK) |-> $stable(parity_last);
	endproperty
	a_parity_latch: assert property (p_parity_latch) else $error("Parity changed mid multiblock");

	c_full_mb: cover property (tx_valid && tx_block_index == `SHFLA_LAST_BLK && fec_active);
	c_emb_end: cover property (tx_valid && tx_emb_end && tx_block_index == 5'd22);
	c_realign: cover property (tx_valid && sysref_pulse ##1 lemc_edge);
endmodule // shfla_tx_link

`default_nettype wire

/* test/shfla_rx_model.sv */
// Receiver model: rebuilds each sync header stream and checks it.
// Assumes blocks arrive on tx_valid in order, block 0 first after reset.
`timescale 1ns/1ps
`default_nettype none

module shfla_rx_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic fec,
	input wire logic [7:0] emb_e,
	input wire logic tx_valid,
	input wire shfla_pkg::shfla_blk_type tx_block,
	input wire logic [4:0] tx_block_index,
	output logic [15:0] hdr_errs,
	output logic [15:0] stream_errs,
	output logic [15:0] mbs
);
	logic [4:0] idx;
	logic [7:0] mb;
	logic [25:0] par, prev;
	logic [31:0] sh, want;
	logic fb;
	always @(posedge clock) begin
		if (rst) begin
			idx = 5'h0;
			mb = 8'h0;
			prev = 26'h0;
			hdr_errs = 16'h0;
			stream_errs = 16'h0;
			mbs = 16'h0;
		end else if (tx_valid) begin
			if (idx == 5'h0)
				par = 26'h0;
			for (int i = 63; i >= 0; i--) begin
				fb = tx_block.data[i] ^ par[25];
				par = {par[24:0], 1'b0} ^ (fb ? 26'h022_0211 : 26'h0);
			end
			if (((tx_block.hdr !== 2'h1) && (tx_block.hdr !== 2'h2)) || (tx_block_index !== idx))
				hdr_errs++;
			sh[idx] = (tx_block.hdr === 2'h1);
			if (idx == 5'h1F) begin
				want = 32'h8000_0000;
				want[22] = (mb + 8'h1 >= emb_e);
				for (int i = 0; i < 26; i++)
					want[i < 22 ? i : i + 1] = fec & prev[25 - i];
				if (sh !== want)
					stream_errs++;
				prev = par;
				mb = (mb + 8'h1 >= emb_e) ? 8'h0 : mb + 8'h1;
				mbs++;
			end
			idx++;
		end
	end
endmodule // shfla_rx_model
`default_nettype wire

/* test/shfla_tx_link_tb.sv */
// Testbench for the sync header stream encoder.
// Assumes the receiver model checks every complete multiblock that it sees.
`timescale 1ns/1ps
`default_nettype none

module shfla_tx_link_tb;
	logic clock, rst, en, sysref, bv, tx_valid, emb_end, lemc_edge, fec_active, pwr_dn, clk_en;
	logic [1:0] mode;
	logic [3:0] pe, pe_out;
	logic [7:0] emb;
	logic [63:0] bd;
	shfla_pkg::shfla_blk_type tx_block;
	logic [4:0] idx;
	logic [25:0] par_last;
	logic [15:0] hdr_errs, stream_errs, mbs;
	integer seed, failures, check_count, cycles;

	shfla_tx_link dut (.clock(clock), .rst(rst), .link_block_enable(en), .sync_header_mode_select(mode),
		.serializer_preemphasis_level(pe), .emb_multiblocks(emb), .sysref_pulse(sysref), .blk_valid(bv),
		.blk_data(bd), .tx_valid(tx_valid), .tx_block(tx_block), .tx_block_index(idx), .tx_emb_end(emb_end),
		.lemc_edge(lemc_edge), .fec_active(fec_active), .parity_last(par_last), .serializer_power_down(pwr_dn),
		.link_clock_enable(clk_en), .preemph_drive(pe_out));

	shfla_rx_model rx (.clock(clock), .rst(rst || !en), .fec(mode == 2'h2), .emb_e(emb), .tx_valid(tx_valid),
		.tx_block(tx_block), .tx_block_index(idx), .hdr_errs(hdr_errs), .stream_errs(stream_errs), .mbs(mbs));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s exp %h got %h", name, exp, got);
		end
	endtask

	task automatic summarize();
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			summarize();
		end
	end

	// Disable, reconfigure, align on sysref, send four multiblocks plus a partial one
	task automatic run(input logic [1:0] m, input logic [7:0] e);
		int n;
		en = 1'b0;
		bv = 1'b0;
		@(negedge clock);
		@(negedge clock);
		chk("power_down", 32'h1, 32'(pwr_dn));
		chk("clock_enable", 32'h0, 32'(clk_en));
		chk("tx_valid_off", 32'h0, 32'(tx_valid));
		mode = m;
		emb = e;
		pe = 4'($random(seed));
		@(negedge clock);
		en = 1'b1;
		bv = 1'b1;
		bd = (e == 8'h3) ? 64'h0 : {$random(seed), $random(seed)};
		repeat (2) @(negedge clock);
		chk("dropped_block", 32'h0, 32'(tx_valid));
		sysref = 1'b1;
		@(negedge clock);
		sysref = 1'b0;
		chk("lemc_edge", 32'h1, 32'(lemc_edge));
		chk("first_index", 32'h0, 32'(idx));
		chk("preemphasis", 32'(pe), 32'(pe_out));
		chk("fec_active", 32'(m == 2'h2), 32'(fec_active));
		chk("clock_enable", 32'h1, 32'(clk_en));
		n = 1;
		while (n < 32 * 4 + 5) begin
			bv = ($random(seed) & 3) != 0;
			bd = (n < 32) ? {64{n[0]}} : {$random(seed), $random(seed)};
			if (bv)
				n++;
			@(negedge clock);
		end
		bv = 1'b0;
		repeat (3) @(negedge clock);
		chk("multiblocks", 32'h4, 32'(mbs));
		chk("header_errors", 32'h0, 32'(hdr_errs));
		chk("stream_errors", 32'h0, 32'(stream_errs));
	endtask

	initial begin
		seed = 32'h0000_bcc6;
		failures = 0;
		check_count = 0;
		cycles = 0;
		rst = 1'b1;
		en = 1'b0;
		sysref = 1'b0;
		bv = 1'b0;
		mode = 2'h2;
		pe = 4'h0;
		emb = 8'h1;
		bd = 64'h0;
		repeat (2) @(negedge clock);
		chk("reset_power_down", 32'h1, 32'(pwr_dn));
		rst = 1'b0;
		run(2'h2, 8'h1);
		run(2'h2, 8'h3);
		run(2'h0, 8'h2);
		run(2'h1, 8'h1);
		run(2'h3, 8'h5);
		run(2'h2, 8'h4);
		summarize();
	end
endmodule // shfla_tx_link_tb
`default_nettype wire
